// ==== dv/sadc_frame_ctrl_test.sv ====
`timescale 1ns/1ps
module sadc_frame_ctrl_test;
  logic        clock_i;
  logic        arst_n_i;
  logic        sel_n;
  logic        sclk;
  logic        sdo;
  logic        sdo_oe_n;
  logic [9:0]  sample;
  logic        powered;
  logic        valid;
  logic [15:0] w;
  int          fails;
  int          cmp_count;

  sadc_frame_ctrl dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .frame_sel_n_i(sel_n), .serial_clk_i(sclk),
    .serial_result_out_o(sdo), .serial_result_oe_n_o(sdo_oe_n), .sample_i(sample), .powered_o(powered),
    .result_valid_o(valid));
  sadc_host_model host (.clock_i(clock_i), .serial_result_out_i(sdo), .serial_result_oe_n_i(sdo_oe_n),
    .frame_sel_n_o(sel_n), .serial_clk_o(sclk));

  // Clock at 200 MHz
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Dummy frame after reset, then a word at the top of the code range and a mid-range word
  task automatic t_full();
    host.frame(16, w);
    check({15'h0000, valid}, 16'h0000, "dummy valid");
    sample = 10'h3FF;
    host.frame(16, w);
    check(w, {3'b000, 10'h3FF, 3'b000}, "word max");
    check({14'h0000, valid, sdo_oe_n}, 16'h0003, "valid released");
    sample = 10'h2A5;
    host.frame(16, w);
    check(w, {3'b000, 10'h2A5, 3'b000}, "word mid");
  endtask
  // Select glitch after one fall keeps the mode
  task automatic t_glitch();
    host.frame(1, w);
    check({14'h0000, powered, sdo_oe_n}, 16'h0003, "glitch");
  endtask
  // Shutdown at the second fall, failed wake, full wake
  task automatic t_shdn();
    host.frame(2, w);
    check({14'h0000, powered, sdo_oe_n}, 16'h0001, "shutdown");
    host.frame(9, w);
    check({15'h0000, powered}, 16'h0000, "wake short");
    host.frame(16, w);
    check({14'h0000, powered, valid}, 16'h0002, "wake full");
    sample = 10'h001;
    host.frame(16, w);
    check({w[14:0], valid}, {2'b00, 10'h001, 2'b00, 2'b01}, "after wake");
  endtask
  // Rises after the tenth and the fourteenth fall abort but stay powered
  task automatic t_abort();
    sample = 10'h3FF;
    host.frame(10, w);
    check({14'h0000, powered, sdo_oe_n}, 16'h0003, "abort");
    check(w, {3'b000, 10'h3FF, 3'b000} & 16'hFFC0, "truncated word");
    host.frame(14, w);
    check({14'h0000, powered, sdo_oe_n}, 16'h0003, "late abort");
    check(w, {3'b000, 10'h3FF, 3'b000}, "word to fourteenth");
  endtask
  // Shutdown, then reset in mid-run: normal mode again and a dummy first frame
  task automatic t_reset();
    host.frame(2, w);
    @(negedge clock_i) arst_n_i = 1'b0;
    repeat (10) @(negedge clock_i);
    check({13'h0000, powered, valid, sdo_oe_n}, 16'h0005, "reset state");
    arst_n_i = 1'b1;
    sample = 10'h155;
    host.frame(16, w);
    check({w[14:0], valid}, {2'b00, 10'h155, 3'b000, 1'b0}, "dummy after reset");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n_i  = 1'b0;
    sample    = 10'h000;
    fails     = 0;
    cmp_count = 0;
    repeat (10) @(negedge clock_i);
    arst_n_i = 1'b1;
    t_full();
    t_glitch();
    t_shdn();
    t_abort();
    t_reset();
    final_report();
  end
  // Watchdog: twelve frames of at most about 640 clocks each fit well inside
  initial begin
    #200000;
    fails++;
    final_report();
  end
endmodule

// ==== dv/sadc_host_model.sv ====
`timescale 1ns/1ps
module sadc_host_model (
  // Clock and link pins
  input  wire logic clock_i,
  input  wire logic serial_result_out_i,
  input  wire logic serial_result_oe_n_i,
  output logic      frame_sel_n_o,
  output logic      serial_clk_o
);
  logic last_bit = 1'b0;
  wire  line;
  // Released line shows the inverse of the last bit so a stale value never passes
  assign line = serial_result_oe_n_i ? ~last_bit : serial_result_out_i;
  always @(posedge clock_i) if (!serial_result_oe_n_i) last_bit <= serial_result_out_i;
  // Serial clock idles high and stands still between frames
  initial begin
    frame_sel_n_o = 1'b1;
    serial_clk_o  = 1'b1;
  end
  // One frame of n falls; select rises half a period after the last fall
  task automatic frame(input int n, output logic [15:0] w);
    w = 16'h0000;
    @(negedge clock_i) frame_sel_n_o = 1'b0;
    for (int k = 1; k <= n; k++) begin
      repeat (16) @(negedge clock_i);
      w[16-k] = line;
      serial_clk_o = 1'b0;
      repeat (16) @(negedge clock_i);
      serial_clk_o = 1'b1;
    end
    frame_sel_n_o = 1'b1;
    repeat (128) @(negedge clock_i);
  endtask
endmodule

// ==== hw/sadc_frame_ctrl.sv ====
`timescale 1ns/1ps
module sadc_frame_ctrl #(
  parameter int unsigned RES_W = sadc_pkg::RES_BITS
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  // Serial link pins
  input  wire logic             frame_sel_n_i,
  input  wire logic             serial_clk_i,
  output logic                  serial_result_out_o,
  output logic                  serial_result_oe_n_o,
  // Analog side and status
  input  wire logic [RES_W-1:0] sample_i,
  output logic                  powered_o,
  output logic                  result_valid_o
);
  import sadc_pkg::*;

  // Elaboration checks; the shifter and the 5-bit counters hold one word only
  if (RES_W != RES_BITS || LEAD_ZEROS + RES_W + 2 > FRAME_EDGES) begin : g_res_check
    $error("result width must equal the converter resolution");
  end
  if (FRAME_EDGES > 31 || SHDN_LAST >= FRAME_EDGES || SHDN_FIRST >= SHDN_LAST) begin : g_count_check
    $error("frame edge counts do not fit the edge counter");
  end
  if (FULL_RATE_DIV > 31 || FULL_RATE_DIV < FRAME_EDGES) begin : g_rate_check
    $error("throughput period does not fit the rate counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage only feeds the second
  logic cs_m, cs_s, cs_d, sk_m, sk_s, sk_d;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      sk_m <= 1'b0;
      sk_s <= 1'b0;
      sk_d <= 1'b0;
    end else begin
      cs_m <= frame_sel_n_i;
      cs_s <= cs_m;
      cs_d <= cs_s;
      sk_m <= serial_clk_i;
      sk_s <= sk_m;
      sk_d <= sk_s;
    end
  end

  logic cs_fall, cs_rise, sk_fall;
  assign cs_fall = cs_d & ~cs_s;
  assign cs_rise = ~cs_d & cs_s;
  assign sk_fall = sk_d & ~sk_s;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state and falling-edge count
  sadc_state_e state;
  logic [4:0]  edges;
  logic        pwr_frame;   // Frame started in shutdown or with no full frame since reset or shutdown
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= SADC_IDLE;
      edges <= EDGE_CNT_RST;
    end else begin
      case (state)
        SADC_IDLE: begin
          if (cs_fall) begin
            state <= SADC_FRAME;
            edges <= EDGE_CNT_RST;
          end
        end
        SADC_FRAME: begin
          if (cs_rise) begin
            state <= SADC_IDLE;
          end else if (sk_fall) begin
            edges <= edges + 5'h01;
            if (edges == 5'(FRAME_EDGES - 1)) state <= SADC_DONE;
          end
        end
        SADC_DONE: begin
          // Select idled low must rise before a new frame
          if (cs_s) state <= SADC_IDLE;
        end
        default: state <= SADC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode; reset picks normal, host dummy frame covers the unknown start
  logic powered, valid_next;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      powered    <= 1'b1;
      pwr_frame  <= 1'b1;
      valid_next <= 1'b0;
    end else begin
      if (state == SADC_IDLE && cs_fall) begin
        pwr_frame <= ~powered | ~valid_next;
      end
      if (state == SADC_FRAME && cs_rise) begin
        // Glitch guard: below two edges nothing changes
        if (edges >= 5'(SHDN_FIRST) && edges < 5'(SHDN_LAST)) begin
          powered    <= 1'b0;
          valid_next <= 1'b0;
        end else if (edges >= 5'(SHDN_LAST) && pwr_frame) begin
          powered    <= 1'b1;
        end
      end
      // An abort wins over a serial clock fall in the same cycle, as in the
      // frame state, so a late rise never half-powers the converter
      if (state == SADC_FRAME && sk_fall && !cs_rise && edges == 5'(FRAME_EDGES - 1)) begin
        powered    <= 1'b1;
        valid_next <= 1'b1;
      end
      if (state == SADC_FRAME && sk_fall && !cs_rise && edges == 5'(SHDN_LAST - 1)) begin
        powered <= 1'b1;
      end
    end
  end
  assign powered_o = powered;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock falls since the last frame start, saturating at the full-rate period.
  // Only a monitor: pacing is left to the host, an early start is never refused.
  logic [4:0] rate_gap;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_gap <= EDGE_CNT_RST;
    end else if (state == SADC_IDLE && cs_fall) begin
      rate_gap <= EDGE_CNT_RST;
    end else if (sk_fall && rate_gap != 5'(FULL_RATE_DIV)) begin
      rate_gap <= rate_gap + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter; aborted or finished frames release the pin
  // The sixteenth capture sees a filler zero after the two trailing zeros
  logic [15:0] shreg;
  logic        drive, valid_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shreg   <= 16'h0000;
      drive   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      if (state == SADC_IDLE && cs_fall) begin
        shreg   <= {3'b000, sample_i, 2'b00, 1'b0};
        drive   <= 1'b1;
        valid_q <= powered & valid_next;
      end else if (state == SADC_FRAME && cs_rise) begin
        drive <= 1'b0;
      end else if (state == SADC_FRAME && sk_fall) begin
        shreg <= {shreg[14:0], 1'b0};
        if (edges == 5'(FRAME_EDGES - 1)) drive <= 1'b0;
      end
    end
  end
  assign serial_result_out_o  = shreg[15];
  assign serial_result_oe_n_o = ~drive;
  assign result_valid_o       = valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  frame_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && sk_fall && edges == 5'd15 |=> serial_result_oe_n_o)
    else $error("output not released after sixteenth edge");
  abort_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && cs_rise |=> serial_result_oe_n_o && state == SADC_IDLE)
    else $error("abort did not release output");
  shutdown_entry_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && cs_rise && edges >= 5'd2 && edges < 5'd10 |=> !powered)
    else $error("no shutdown on mid-frame abort");
  glitch_guard_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && cs_rise && edges < 5'd2 |=> powered == $past(powered))
    else $error("mode changed on early glitch");
  start_drive_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_IDLE && cs_fall |=> !serial_result_oe_n_o ##0 !serial_result_out_o)
    else $error("frame start did not drive output");
  wake_invalid_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_IDLE && cs_fall && !powered |=> !result_valid_o)
    else $error("wake frame marked valid");
  full_power_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && sk_fall && edges == 5'd15 |=> powered && state == SADC_DONE)
    else $error("not powered after full frame");
  lead_zero_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && edges < 5'd3 && !serial_result_oe_n_o |-> !serial_result_out_o)
    else $error("leading zero missing");
  new_frame_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_DONE |=> state != SADC_FRAME)
    else $error("frame restarted without select rising");

  // Power mode, shifting and release between frames
  idle_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state != SADC_FRAME |-> serial_result_oe_n_o)
    else $error("output driven outside a frame");
  wake_fallback_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && cs_rise && !powered && edges < 5'd10 |=> !powered)
    else $error("short wake frame left shutdown");
  wake_power_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && sk_fall && !cs_rise && edges == 5'd9 |=> powered)
    else $error("not powered after tenth edge");
  stay_normal_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && cs_rise && edges >= 5'd10 |=> powered)
    else $error("late abort left normal mode");
  valid_after_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_IDLE && cs_fall && powered && valid_next |=> result_valid_o)
    else $error("frame after wake not valid");
  shift_step_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_FRAME && sk_fall && !cs_rise && edges < 5'd15 |=> serial_result_out_o == $past(shreg[14]))
    else $error("result bit not shifted on serial fall");
  shutdown_keep_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    state == SADC_IDLE && !powered |=> !powered)
    else $error("left shutdown without select falling");
  full_frame_c: cover property (@(posedge clock_i) state == SADC_FRAME ##1 state == SADC_DONE);
  shutdown_c:   cover property (@(posedge clock_i) $fell(powered));
  wake_c:       cover property (@(posedge clock_i) $rose(powered));
  abort_c:      cover property (@(posedge clock_i) state == SADC_FRAME && cs_rise && edges > 5'd10);
  full_rate_c:  cover property (@(posedge clock_i) state == SADC_IDLE && cs_fall && rate_gap >= 5'(FRAME_EDGES));
endmodule

// ==== hw/sadc_pkg.sv ====
package sadc_pkg;
  localparam int unsigned RES_BITS      = 10;
  localparam int unsigned LEAD_ZEROS    = 3;
  localparam int unsigned FRAME_EDGES   = 16;
  localparam int unsigned SHDN_FIRST    = 2;
  localparam int unsigned SHDN_LAST     = 10;
  localparam int unsigned FULL_RATE_DIV = 20;
  localparam logic [4:0]  EDGE_CNT_RST  = 5'h00;
  localparam logic [9:0]  SAMPLE_RST    = 10'h000;
  typedef enum logic [1:0] {
    SADC_IDLE  = 2'b00,
    SADC_FRAME = 2'b01,
    SADC_DONE  = 2'b11
  } sadc_state_e;
endpackage
